// File: bsm_readout.sv
/*
  Slave end of the breaker status readout: takes request bytes, checks
  the frame and answers a holding-register read with the status dataset
  or an exception.
  Assumes a byte receiver and transmitter on the same clock outside,
  contact and strap pins from the breaker, and the remaining dataset
  registers served combinationally through the external read port.
*/
`timescale 1ns/100ps
module bsm_readout
  import bsm_pkg::*;
#(
  parameter int unsigned GAP_CYCLES     = FRAME_GAP_CYCLES,
  parameter int unsigned REFRESH_PERIOD = REFRESH_CYCLES
)
(
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic [7:0]    slave_address,
  input  wire bsm_contacts_t contacts,
  input  wire bsm_contacts_t contact_valid,
  input  wire logic          motor_mechanism,
  input  wire logic          data_available,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  input  wire logic          tx_ready,
  output logic               tx_valid,
  output logic      [7:0]    tx_data,
  output logic      [15:0]   ext_rd_addr,
  input  wire logic [15:0]   ext_rd_data
);

  typedef enum {S_RX, S_EVAL, S_SEND} bsm_state_t;

  localparam int unsigned SYNC_W = 20;

  // Pin synchroniser; only the second stage is read.
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  bsm_contacts_t     c_s;
  bsm_contacts_t     v_s;
  logic              motor_s;
  logic              avail_s;
  logic [7:0]        slave_s;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {contacts, contact_valid, motor_mechanism,
                  data_available, slave_address};
      sync2_q <= sync1_q;
    end
  end

  assign {c_s, v_s, motor_s, avail_s, slave_s} = sync2_q;

  // Refresh divider and snapshot of the status and quality words.
  logic [31:0] refresh_cnt_q;
  logic [31:0] refresh_cnt_d;
  logic        refresh_tick;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] quality_q;
  logic [15:0] quality_d;

  always_comb begin
    refresh_tick  = (refresh_cnt_q == REFRESH_PERIOD - 1);
    refresh_cnt_d = refresh_tick ? '0 : refresh_cnt_q + 32'h00000001;
    status_d  = status_q;
    quality_d = quality_q;
    if (refresh_tick) begin
      // Reserved bits stay 0 in both words.
      status_d  = '0;
      quality_d = '0;
      status_d[BIT_CLOSED]   = c_s.closed_position_contact;
      quality_d[BIT_CLOSED]  = v_s.closed_position_contact;
      // A motor mechanism has no trip, spring or ready contact; the
      // forced zero is a known value, so its quality reads valid.
      status_d[BIT_TRIP]     = c_s.trip_indication_contact
                               & ~motor_s;
      quality_d[BIT_TRIP]    = v_s.trip_indication_contact | motor_s;
      status_d[BIT_FAULT]    = c_s.fault_trip_contact;
      quality_d[BIT_FAULT]   = v_s.fault_trip_contact;
      status_d[BIT_SPRING]   = c_s.spring_charged_contact
                               & ~motor_s;
      quality_d[BIT_SPRING]  = v_s.spring_charged_contact | motor_s;
      status_d[BIT_READY]    = c_s.ready_to_close_contact
                               & ~motor_s;
      quality_d[BIT_READY]   = v_s.ready_to_close_contact | motor_s;
      status_d[BIT_UNAVAIL]  = ~avail_s;
      quality_d[BIT_UNAVAIL] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      refresh_cnt_q <= '0;
      status_q      <= STATUS_RESET;
      quality_q     <= QUALITY_RESET;
    end else begin
      refresh_cnt_q <= refresh_cnt_d;
      status_q      <= status_d;
      quality_q     <= quality_d;
    end
  end

  // Request reception, frame check and answer transmission.
  bsm_state_t   state_q;
  bsm_state_t   state_d;
  logic [3:0]   rx_cnt_q;
  logic [3:0]   rx_cnt_d;
  logic [31:0]  gap_cnt_q;
  logic [31:0]  gap_cnt_d;
  bsm_request_t req_q;
  bsm_request_t req_d;
  logic [7:0]   exc_q;
  logic [7:0]   exc_d;
  logic [8:0]   idx_q;
  logic [8:0]   idx_d;
  logic [8:0]   last_q;
  logic [8:0]   last_d;
  logic [15:0]  rd_addr_q;
  logic [15:0]  rd_addr_d;
  logic         tx_valid_q;
  logic         tx_valid_d;
  logic [7:0]   tx_data_q;
  logic [7:0]   tx_data_d;

  logic         rx_take;
  logic         rx_crc_init;
  logic [15:0]  rx_crc;
  logic         tx_crc_en;
  logic         tx_crc_init;
  logic [15:0]  tx_crc;
  logic         load;
  logic [15:0]  reg_val;
  logic [16:0]  end_addr;
  logic [8:0]   data_idx;

  // The two dataset words live here; every other dataset address is
  // answered by the external port for the current read address.
  always_comb begin
    if (rd_addr_q == ADDR_QUALITY) begin
      reg_val = quality_q;
    end else if (rd_addr_q == ADDR_STATUS) begin
      reg_val = status_q;
    end else begin
      reg_val = ext_rd_data;
    end
  end

  assign rx_take     = (state_q == S_RX) && rx_valid;
  assign rx_crc_init = (rx_cnt_q == 4'h0);
  assign end_addr    = {1'b0, req_q.start} + {1'b0, req_q.count}
                       - 17'h00001;
  assign load        = (state_q == S_SEND) && (!tx_valid_q || tx_ready);
  assign data_idx    = idx_q - HDR_BYTES;

  always_comb begin
    state_d     = state_q;
    rx_cnt_d    = rx_cnt_q;
    gap_cnt_d   = gap_cnt_q;
    req_d       = req_q;
    exc_d       = exc_q;
    idx_d       = idx_q;
    last_d      = last_q;
    rd_addr_d   = rd_addr_q;
    tx_valid_d  = tx_valid_q;
    tx_data_d   = tx_data_q;
    tx_crc_en   = 1'b0;
    tx_crc_init = 1'b0;
    case (state_q)
      S_RX: begin
        if (rx_valid) begin
          gap_cnt_d = '0;
          // Bytes past the eighth are ignored in S_EVAL and S_SEND; back in S_RX they start a new frame.
          if (rx_cnt_q != REQ_BYTES) begin
            rx_cnt_d = rx_cnt_q + 4'h1;
            case (rx_cnt_q)
              4'h0: req_d.slave        = rx_data;
              4'h1: req_d.func         = rx_data;
              4'h2: req_d.start[15:8]  = rx_data;
              4'h3: req_d.start[7:0]   = rx_data;
              4'h4: req_d.count[15:8]  = rx_data;
              4'h5: req_d.count[7:0]   = rx_data;
              default: ;
            endcase
            if (rx_cnt_q == REQ_BYTES - 4'h1) begin
              state_d = S_EVAL;
            end
          end
        end else if (gap_cnt_q >= GAP_CYCLES - 1) begin
          rx_cnt_d = '0;
        end else begin
          gap_cnt_d = gap_cnt_q + 32'h00000001;
        end
      end
      S_EVAL: begin
        rx_cnt_d  = '0;
        gap_cnt_d = '0;
        idx_d     = '0;
        // Start address is the register number minus one.
        rd_addr_d = req_q.start;
        exc_d     = '0;
        if (req_q.func != FC_READ_HOLDING) begin
          exc_d = EXC_BAD_FUNCTION;
        end else if (req_q.count == 16'h0000 ||
                     req_q.count > MAX_READ_REGS) begin
          exc_d = EXC_BAD_VALUE;
        end else if (req_q.start < DATASET_FIRST ||
                     end_addr > {1'b0, DATASET_LAST}) begin
          exc_d = EXC_BAD_ADDRESS;
        end
        last_d = (exc_d != 8'h00) ? HDR_BYTES
                 : HDR_BYTES + {req_q.count[7:0], 1'b0};
        // A bad CRC, a broadcast or another slave gets no answer.
        if (rx_crc == 16'h0000 && req_q.slave == slave_s &&
            req_q.slave != BROADCAST_ADDR) begin
          state_d = S_SEND;
        end else begin
          state_d = S_RX;
        end
      end
      S_SEND: begin
        if (load) begin
          tx_valid_d = 1'b1;
          tx_crc_en  = (idx_q < last_q);
          idx_d      = idx_q + 9'h001;
          if (idx_q == 9'h000) begin
            tx_crc_init = 1'b1;
            tx_data_d   = req_q.slave;
          end else if (idx_q == 9'h001) begin
            tx_data_d = (exc_q != 8'h00) ? (req_q.func | FC_EXCEPTION)
                        : req_q.func;
          end else if (idx_q == 9'h002) begin
            tx_data_d = (exc_q != 8'h00) ? exc_q
                        : {req_q.count[6:0], 1'b0};
          end else if (idx_q < last_q) begin
            if (!data_idx[0]) begin
              tx_data_d = reg_val[15:8];
            end else begin
              tx_data_d = reg_val[7:0];
              rd_addr_d = rd_addr_q + 16'h0001;
            end
          end else if (idx_q == last_q) begin
            tx_data_d = tx_crc[7:0];
          end else if (idx_q == last_q + 9'h001) begin
            tx_data_d = tx_crc[15:8];
          end else begin
            tx_valid_d = 1'b0;
            idx_d      = idx_q;
            state_d    = S_RX;
          end
        end
      end
      default: begin
        state_d = S_RX;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q    <= S_RX;
      rx_cnt_q   <= '0;
      gap_cnt_q  <= '0;
      req_q      <= '0;
      exc_q      <= '0;
      idx_q      <= '0;
      last_q     <= '0;
      rd_addr_q  <= '0;
      tx_valid_q <= 1'b0;
      tx_data_q  <= '0;
    end else begin
      state_q    <= state_d;
      rx_cnt_q   <= rx_cnt_d;
      gap_cnt_q  <= gap_cnt_d;
      req_q      <= req_d;
      exc_q      <= exc_d;
      idx_q      <= idx_d;
      last_q     <= last_d;
      rd_addr_q  <= rd_addr_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q  <= tx_data_d;
    end
  end

  // Receive CRC runs over the CRC bytes too, so a good frame leaves 0.
  bsm_crc16 u_rx_crc (
    .clock (clock),
    .nrst  (nrst),
    .init  (rx_crc_init),
    .en    (rx_take && rx_cnt_q != REQ_BYTES),
    .data  (rx_data),
    .crc   (rx_crc)
  );

  bsm_crc16 u_tx_crc (
    .clock (clock),
    .nrst  (nrst),
    .init  (tx_crc_init),
    .en    (tx_crc_en),
    .data  (tx_data_d),
    .crc   (tx_crc)
  );

  assign tx_valid    = tx_valid_q;
  assign tx_data     = tx_data_q;
  assign ext_rd_addr = rd_addr_q;

endmodule

// File: bsm_pkg.sv
/*
  Shared constants and types of the breaker status readout slave: frame
  field values, dataset address window, status bit positions, reset
  values and timing counts.
  Assumes a 100 MHz system clock and a byte-wide serial link whose
  character framing is handled outside the block.
*/
// Contract
// - A register is addressed in the frame by its number minus one, so the first quality register sits at 0x7CFF.
// - The answer echoes the slave address and function code, then a byte count, the register values and a CRC.
// - The byte count of the answer is twice the number of registers asked for.
// - Each register goes out high byte first, and lower-numbered registers go out first.
// - Each quality bit is 1 when the same bit of the next status word is valid and 0 when it is not.
// - Status bit 0 is 0 for an open breaker and 1 for a closed one.
// - Status bit 1 shows a trip of any cause and is always 0 on a motor mechanism.
// - Status bit 2 shows only a trip on electrical fault, tests included, and is 0 otherwise.
// - Status bit 3 shows a charged closing spring and is always 0 on a motor mechanism.
// - Status bit 5 shows ready to close and is always 0 on a motor mechanism.
// - Status bit 15 set means data is unavailable and every other status bit is then meaningless.
// - The dataset spans register numbers 32000 to 32341 and is refreshed periodically.
package bsm_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  // Silence that closes a request frame, a least time.
  localparam int unsigned FRAME_GAP_US    = 1750;
  localparam int unsigned FRAME_GAP_CYCLES =
    (FRAME_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Period at which the contact snapshot is refreshed.
  localparam int unsigned REFRESH_US      = 1000;
  localparam int unsigned REFRESH_CYCLES  =
    (REFRESH_US * 1000) / CLK_PERIOD_NS;

  localparam logic [15:0] ADDR_QUALITY    = 16'h7CFF;
  localparam logic [15:0] ADDR_STATUS     = 16'h7D00;
  localparam logic [15:0] DATASET_FIRST   = 16'h7CFF;
  localparam logic [15:0] DATASET_LAST    = 16'h7E54;
  localparam logic [15:0] MAX_READ_REGS   = 16'h007D;

  localparam logic [7:0]  FC_READ_HOLDING = 8'h03;
  localparam logic [7:0]  FC_EXCEPTION    = 8'h80;
  localparam logic [7:0]  EXC_BAD_FUNCTION = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDRESS = 8'h02;
  localparam logic [7:0]  EXC_BAD_VALUE   = 8'h03;
  localparam logic [7:0]  BROADCAST_ADDR  = 8'h00;
  localparam logic [3:0]  REQ_BYTES       = 4'h8;
  localparam logic [8:0]  HDR_BYTES       = 9'h003;

  localparam logic [15:0] CRC_INIT        = 16'hFFFF;
  localparam logic [15:0] CRC_POLY        = 16'hA001;

  localparam int unsigned BIT_CLOSED      = 0;
  localparam int unsigned BIT_TRIP        = 1;
  localparam int unsigned BIT_FAULT       = 2;
  localparam int unsigned BIT_SPRING      = 3;
  localparam int unsigned BIT_READY       = 5;
  localparam int unsigned BIT_UNAVAIL     = 15;

  // Until the first refresh the data is marked unavailable.
  localparam logic [15:0] STATUS_RESET    = 16'h8000;
  localparam logic [15:0] QUALITY_RESET   = 16'h0000;

  typedef struct packed {
    logic closed_position_contact;
    logic trip_indication_contact;
    logic fault_trip_contact;
    logic spring_charged_contact;
    logic ready_to_close_contact;
  } bsm_contacts_t;

  typedef struct packed {
    logic [7:0]  slave;
    logic [7:0]  func;
    logic [15:0] start;
    logic [15:0] count;
  } bsm_request_t;

endpackage

// File: bsm_crc16.sv
/*
  Running CRC-16 over a byte stream, reflected polynomial, one byte per
  cycle.
  Assumes the caller raises init together with the first byte's enable.
*/
`timescale 1ns/100ps
module bsm_crc16
  import bsm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  function automatic logic [15:0] crc_byte(input logic [15:0] seed,
                                           input logic [7:0]  b);
    logic [15:0] c;
    c = seed ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  always_comb begin
    crc_d = crc_q;
    if (en) begin
      crc_d = crc_byte(init ? CRC_INIT : crc_q, data);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;

endmodule

// File: bsm_readout_assertions.sv
/*
  Concurrent checks on the ports of the breaker status readout slave.
  Assumes one clock domain, synchronous active-low reset, bound by name.
*/
`timescale 1ns/100ps
module bsm_readout_assertions
  import bsm_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  slave_address,
  input wire logic        rx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic [15:0] ext_rd_addr
);
  a_reset_quiet: assert property (
    @(posedge clock)
    !nrst |=> !tx_valid && ext_rd_addr == 16'h0000)
    else $error("output active after reset");
  a_hold_byte: assert property (
    @(posedge clock) disable iff (!nrst)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("answer byte dropped before acceptance");
  a_first_slave: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(tx_valid) |-> tx_data == slave_address)
    else $error("answer does not open with own address");
  a_func_echo: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(tx_valid) && tx_ready
    |=> tx_valid && (tx_data == FC_READ_HOLDING || tx_data[7]))
    else $error("function code not echoed");
  a_byte_count: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(tx_valid) && tx_ready ##1 tx_ready && tx_data == FC_READ_HOLDING
    |=> tx_data[0] == 1'b0 && tx_data <= 8'hFA && tx_data != 8'h00)
    else $error("byte count out of range");
  a_exc_code: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(tx_valid) && tx_ready ##1 tx_ready && tx_data[7]
    |=> tx_data inside {8'h01, 8'h02, 8'h03})
    else $error("bad exception code");
  // The last request byte is taken one edge, evaluated the next, and the
  // first answer byte is loaded on the third, so it shows one edge later.
  a_answer_time: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(tx_valid) |-> $past(rx_valid, 3))
    else $error("answer not three cycles after last byte");
  a_addr_step: assert property (
    @(posedge clock) disable iff (!nrst)
    tx_valid && $past(tx_valid) && ext_rd_addr != $past(ext_rd_addr)
    |-> ext_rd_addr == $past(ext_rd_addr) + 16'h0001)
    else $error("register address not ascending by one");
  a_done_bounded: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(tx_valid) |-> ##[1:1000] !tx_valid)
    else $error("answer never ends");
endmodule

bind bsm_readout bsm_readout_assertions u_bsm_readout_assertions (
  .clock(clock), .nrst(nrst), .slave_address(slave_address),
  .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .ext_rd_addr(ext_rd_addr));

// File: bsm_master.sv
/*
  Behavioural serial-bus master: sends read requests byte by byte and
  collects every answer byte the slave hands over.
  Assumes the slave sits on the same clock; slow makes tx_ready toggle.
*/
`timescale 1ns/100ps
module bsm_master
  import bsm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid = 1'b0,
  output logic      [7:0] rx_data = 8'h00,
  output logic            tx_ready = 1'b0
);
  logic [7:0] got[$];

  always @(posedge clock) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction

  // The master trusts a status bit only where its quality bit is set.
  function automatic logic [15:0] usable(input logic [15:0] q, s);
    return s & q;
  endfunction

  // Only the first n bytes go out, so a torn frame can be made.
  task automatic send(input logic [7:0] sa, fc, input logic [15:0] st, cnt,
                      input logic bad, input int n);
    logic [7:0]  f[$];
    logic [15:0] c;
    f = {sa, fc, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
    c = crc_of(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data  <= f[i];
      @(posedge clock);
      rx_valid <= 1'b0;
      // The line no longer holds the byte once it is sent.
      rx_data  <= ~f[i];
    end
  endtask
endmodule

// File: bsm_readout_tb.sv
/*
  Self-checking bench of the breaker status readout slave.
  Assumes the behavioural master and shortened gap and refresh counts.
*/
`timescale 1ns/100ps
module bsm_readout_tb;
  import bsm_pkg::*;
  typedef struct packed {
    logic [7:0]    func;
    logic [15:0]   start;
    logic [15:0]   count;
    logic [7:0]    exc;
    bsm_contacts_t pins;
    logic          motor;
    logic          avail;
  } bsm_row_t;
  localparam logic [7:0] OWN_ADDR = 8'h5A;
  logic          clock = 1'b0;
  logic          nrst = 1'b0;
  logic          slow = 1'b0;
  logic [7:0]    slave_address = OWN_ADDR;
  bsm_contacts_t contacts = '0;
  bsm_contacts_t contact_valid = '0;
  logic          motor_mechanism = 1'b0;
  logic          data_available = 1'b1;
  logic          rx_valid, tx_ready, tx_valid;
  logic [7:0]    rx_data, tx_data;
  logic [15:0]   ext_rd_addr, ext_rd_data;
  logic [7:0]    exp_q[$];
  int            err_total = 0;
  int            compares = 0;
  bsm_row_t      rows [11] = '{
    '{8'h03, 16'h7CFF, 16'h0002, 8'h00, 5'b10101, 1'b0, 1'b1},
    '{8'h03, 16'h7CFF, 16'h0002, 8'h00, 5'b01010, 1'b0, 1'b1},
    '{8'h03, 16'h7CFF, 16'h0002, 8'h00, 5'b11111, 1'b1, 1'b1},
    '{8'h03, 16'h7CFF, 16'h0002, 8'h00, 5'b00000, 1'b0, 1'b0},
    '{8'h03, 16'h7D00, 16'h007D, 8'h00, 5'b11001, 1'b0, 1'b1},
    '{8'h03, 16'h7E54, 16'h0001, 8'h00, 5'b00000, 1'b0, 1'b1},
    '{8'h03, 16'h7E53, 16'h0003, 8'h02, 5'b00000, 1'b0, 1'b1},
    '{8'h03, 16'h7CFE, 16'h0001, 8'h02, 5'b00000, 1'b0, 1'b1},
    '{8'h03, 16'h7CFF, 16'h0000, 8'h03, 5'b00000, 1'b0, 1'b1},
    '{8'h03, 16'h7CFE, 16'h007E, 8'h03, 5'b00000, 1'b0, 1'b1},
    '{8'h04, 16'h7CFF, 16'h0000, 8'h01, 5'b00000, 1'b0, 1'b1}};

  always #5 clock = ~clock;
  assign ext_rd_data = ext_rd_addr ^ 16'hA5C3;

  bsm_readout #(.GAP_CYCLES(20), .REFRESH_PERIOD(8)) u_bsm_readout (
    .clock(clock), .nrst(nrst), .slave_address(slave_address),
    .contacts(contacts), .contact_valid(contact_valid),
    .motor_mechanism(motor_mechanism), .data_available(data_available),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .ext_rd_addr(ext_rd_addr),
    .ext_rd_data(ext_rd_data));

  bsm_master u_bsm_master (
    .clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));

  task automatic end_of_test();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_word(input logic [15:0] a,
                                           input bsm_row_t r);
    logic [15:0] s, q;
    s = 16'h0000;
    q = 16'h8000;
    s[15] = ~r.avail;
    s[0] = r.pins.closed_position_contact;
    s[1] = r.pins.trip_indication_contact & ~r.motor;
    s[2] = r.pins.fault_trip_contact;
    s[3] = r.pins.spring_charged_contact & ~r.motor;
    s[5] = r.pins.ready_to_close_contact & ~r.motor;
    q[0] = ~r.pins.closed_position_contact;
    q[1] = ~r.pins.trip_indication_contact | r.motor;
    q[2] = ~r.pins.fault_trip_contact;
    q[3] = ~r.pins.spring_charged_contact | r.motor;
    q[5] = ~r.pins.ready_to_close_contact | r.motor;
    if (a == ADDR_QUALITY)
      return q;
    if (a == ADDR_STATUS)
      return s;
    return a ^ 16'hA5C3;
  endfunction

  task automatic run_row(input bsm_row_t r);
    logic [15:0] w;
    logic [15:0] v;
    int          n, k;
    contacts <= r.pins;
    contact_valid <= ~r.pins;
    motor_mechanism <= r.motor;
    data_available <= r.avail;
    repeat (20) @(posedge clock);
    u_bsm_master.got.delete();
    u_bsm_master.send(OWN_ADDR, r.func, r.start, r.count, 1'b0, 8);
    exp_q = {OWN_ADDR};
    if (r.exc != 8'h00)
      exp_q = {exp_q, r.func | FC_EXCEPTION, r.exc};
    else begin
      // The byte count is one queue element, twice the register count.
      exp_q = {exp_q, r.func, 8'(r.count << 1)};
      for (int i = 0; i < r.count; i++) begin
        w = exp_word(r.start + 16'(i), r);
        exp_q = {exp_q, w[15:8], w[7:0]};
      end
    end
    w = u_bsm_master.crc_of(exp_q);
    exp_q = {exp_q, w[7:0], w[15:8]};
    n = exp_q.size();
    for (k = 0; k < 2000 && u_bsm_master.got.size() < n; k++)
      @(posedge clock);
    repeat (4) @(posedge clock);
    check(16'(u_bsm_master.got.size()), 16'(n), "answer length");
    if (k == 2000)
      end_of_test();
    foreach (exp_q[i])
      check(u_bsm_master.got[i], exp_q[i], "answer byte");
    if (r.exc == 8'h00 && r.start == ADDR_QUALITY) begin
      w = u_bsm_master.usable({u_bsm_master.got[3], u_bsm_master.got[4]},
                              {u_bsm_master.got[5], u_bsm_master.got[6]});
      v = exp_word(ADDR_STATUS, r) & exp_word(ADDR_QUALITY, r);
      check(w, v, "usable status");
    end
  endtask

  initial begin
    repeat (10) @(posedge clock);
    check(tx_valid, 1'b0, "valid in reset");
    check(ext_rd_addr, 16'h0000, "address in reset");
    nrst <= 1'b1;
    foreach (rows[i])
      run_row(rows[i]);
    u_bsm_master.send(OWN_ADDR, 8'h03, 16'h7CFF, 16'h0002, 1'b0, 3);
    repeat (30) @(posedge clock);
    run_row(rows[1]);
    slow <= 1'b1;
    run_row(rows[4]);
    u_bsm_master.send(OWN_ADDR, 8'h03, 16'h7CFF, 16'h0002, 1'b0, 8);
    repeat (8) @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(tx_valid, 1'b0, "valid after abort");
    // Release on a clock edge, like every other input of the block.
    @(posedge clock);
    nrst <= 1'b1;
    slow <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      repeat (30) @(posedge clock);
      u_bsm_master.got.delete();
      u_bsm_master.send(k == 0 ? 8'h11 : (k == 1 ? 8'h00 : OWN_ADDR),
                        8'h03, 16'h7CFF, 16'h0002, k == 2, 8);
      repeat (60) @(posedge clock);
      check(16'(u_bsm_master.got.size()), 16'h0000, "stray answer");
    end
    run_row(rows[0]);
    end_of_test();
  end
endmodule
